// ===== common/vsc_map.svh
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH

// Storage organisation
`define VSC_SEG_COUNT    8'hA0
`define VSC_SEG_LAST     8'h9F
`define VSC_SEG_FIRST    8'h00
`define VSC_SEG_STEP     8'h01

// Address field split: top bits select option space
`define VSC_MODE_RANGE   7:6
`define VSC_OPT_RANGE    5:0
`define VSC_MODE_OPTS    2'h3
`define VSC_LOW_CONSEC_SEL 4     // Consecutive option bit in option space

// Segment duration: figure in ns, clock period in ns
`define VSC_SEG_TIME_NS  100000000
`define VSC_CLK_NS       10
`define VSC_SEG_TICKS    (`VSC_SEG_TIME_NS / `VSC_CLK_NS)

// Register byte offsets
`define VSC_AXI_AW       12
`define VSC_WORD_MASK    12'hFFC
`define VSC_REG_CFG      12'h000
`define VSC_REG_STATUS   12'h004
`define VSC_REG_ERASE    12'h008

// Register select codes
`define VSC_SEL_CFG      2'h0
`define VSC_SEL_STATUS   2'h1
`define VSC_SEL_ERASE    2'h2
`define VSC_SEL_NONE     2'h3

// Bus responses and reset values
`define VSC_RESP_OKAY    2'h0
`define VSC_RESP_SLVERR  2'h2
`define VSC_ERASE_BIT    0
`define VSC_ZERO32       32'h0000_0000

`endif

// ===== common/vsc_pkg.sv
package vsc_pkg;

   // Control sequencer states
   typedef enum logic [1:0] {
      VSC_IDLE  = 2'b00,
      VSC_REC   = 2'b01,
      VSC_PLAY  = 2'b10,
      VSC_SLEEP = 2'b11
   } vsc_state_e;

   // Host-side control pins
   typedef struct packed {
      logic       selectN;          // Active-low select
      logic       playDir;          // High play, low record
      logic [7:0] segmentAddr;      // Segment address or options
      logic       lowPowerRequest;  // Low-power request
   } vsc_ctl_in_s;

   // Device-side status pins
   typedef struct packed {
      logic       msgEndFlagN;      // Message end flag, low active
      logic       speakerHold;      // Speaker outputs held at analog ground
      logic       auxRoute;         // Auxiliary input feeds speaker path
      logic       recordActive;     // Record cycle running
      logic       playActive;       // Playback cycle running
      logic       lowPowerMode;     // Very low power state
      logic [7:0] curSegment;       // Current segment pointer
   } vsc_ctl_out_s;

   // Option bits, in address bit order 5 down to 0
   typedef struct packed {
      logic levelPlay;
      logic consec;
      logic loop;
      logic ovfOnly;
      logic eomDel;
      logic cue;
   } vsc_opt_s;

endpackage

// ===== logic/vsc_seg_timer.sv
`timescale 1ns/1ps
// Segment timer: one tick per programmed segment period
module vsc_seg_timer #(
   parameter int unsigned W = 32
) (
   input  wire logic         clk,      // System clock
   input  wire logic         rst,      // Synchronous reset, high
   input  wire logic         run,      // Count while high
   input  wire logic         restart,  // Restart period from zero
   input  wire logic [W-1:0] period,   // Clocks per segment
   output logic              tick      // Last clock of a segment
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] lastCnt;

   // A zero period acts as one so the tick never stalls
   assign lastCnt = (period == '0) ? '0 : W'(period - W'(1));
   assign tick    = run && (cnt_ff == lastCnt);

   // Counter restarts on command and on every tick
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= '0;
      end else if (run) begin
         cnt_ff <= W'(cnt_ff + W'(1));
      end
   end

endmodule

// ===== logic/vsc_control_port.sv
`timescale 1ns/1ps
`include "vsc_map.svh"
module vsc_control_port #(
   parameter int unsigned SEG_TICKS = `VSC_SEG_TICKS
) (
   input  wire logic                      clk,            // 100 MHz clock
   input  wire logic                      rst,            // Synchronous reset, high
   input  wire vsc_pkg::vsc_ctl_in_s      pinIn,          // Control pins
   output vsc_pkg::vsc_ctl_out_s          pinOut,         // Status pins
   input  wire logic [`VSC_AXI_AW-1:0]    s_axi_awaddr,   // Write address
   input  wire logic                      s_axi_awvalid,  // Write address valid
   output logic                           s_axi_awready,  // Write address ready
   input  wire logic [31:0]               s_axi_wdata,    // Write data
   input  wire logic [3:0]                s_axi_wstrb,    // Write byte strobes
   input  wire logic                      s_axi_wvalid,   // Write data valid
   output logic                           s_axi_wready,   // Write data ready
   output logic [1:0]                     s_axi_bresp,    // Write response
   output logic                           s_axi_bvalid,   // Write response valid
   input  wire logic                      s_axi_bready,   // Write response ready
   input  wire logic [`VSC_AXI_AW-1:0]    s_axi_araddr,   // Read address
   input  wire logic                      s_axi_arvalid,  // Read address valid
   output logic                           s_axi_arready,  // Read address ready
   output logic [31:0]                    s_axi_rdata,    // Read data
   output logic [1:0]                     s_axi_rresp,    // Read response
   output logic                           s_axi_rvalid,   // Read data valid
   input  wire logic                      s_axi_rready    // Read data ready
);

   vsc_pkg::vsc_state_e state_ff;
   vsc_pkg::vsc_opt_s   opt_ff;
   logic [7:0]          addrLatch_ff;
   logic                dirLatch_ff;
   logic [7:0]          curSeg_ff;
   logic [7:0]          startSeg_ff;
   logic                selPrev_ff;
   logic                ovf_ff;
   logic                eomLow_ff;
   logic [31:0]         cfgTicks_ff;
   logic                mark_ff [`VSC_SEG_COUNT];
   logic                selFall;
   logic                selRise;
   logic                isOpt;
   logic                start;
   logic                active;
   logic                segTick;
   logic                lastTick;
   logic                endHit;
   logic [7:0]          startVal;
   logic                awHeld_ff;
   logic                wHeld_ff;
   logic [`VSC_AXI_AW-1:0] awAddr_ff;
   logic [31:0]         wData_ff;
   logic [3:0]          wStrb_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                rvalid_ff;
   logic [31:0]         rdata_ff;
   logic [1:0]          rresp_ff;
   logic                doWrite;
   logic [1:0]          wSel;
   logic                eraseReq;

   // Word decode shared by both bus directions
   function automatic logic [1:0] regSel(input logic [`VSC_AXI_AW-1:0] a);
      logic [`VSC_AXI_AW-1:0] w;
      w = a & `VSC_WORD_MASK;
      case (w)
         `VSC_REG_CFG:    regSel = `VSC_SEL_CFG;
         `VSC_REG_STATUS: regSel = `VSC_SEL_STATUS;
         `VSC_REG_ERASE:  regSel = `VSC_SEL_ERASE;
         default:         regSel = `VSC_SEL_NONE;
      endcase
   endfunction

   // Select edges; pins are already synchronous to clk
   assign selFall  = selPrev_ff && !pinIn.selectN;
   assign selRise  = !selPrev_ff && pinIn.selectN;
   assign isOpt    = (pinIn.segmentAddr[`VSC_MODE_RANGE] == `VSC_MODE_OPTS);
   assign active   = (state_ff == vsc_pkg::VSC_REC) || (state_ff == vsc_pkg::VSC_PLAY);
   assign lastTick = segTick && (curSeg_ff == `VSC_SEG_LAST);
   assign endHit   = mark_ff[curSeg_ff];

   // A full device refuses new cycles until low power clears it
   assign start = (state_ff == vsc_pkg::VSC_IDLE) && selFall
                  && !pinIn.lowPowerRequest && !ovf_ff;

   // Start segment: direct address, or pointer kept in consecutive mode
   always_comb begin
      if (isOpt) begin
         startVal = pinIn.segmentAddr[`VSC_LOW_CONSEC_SEL] ? curSeg_ff : `VSC_SEG_FIRST;
      end else if (pinIn.segmentAddr < `VSC_SEG_COUNT) begin
         startVal = pinIn.segmentAddr;
      end else begin
         startVal = `VSC_SEG_FIRST;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         selPrev_ff <= 1'b1;
      end else begin
         selPrev_ff <= pinIn.selectN;
      end
   end

   // Address and direction latch on every select falling edge
   always_ff @(posedge clk) begin
      if (rst) begin
         addrLatch_ff <= `VSC_SEG_FIRST;
         dirLatch_ff  <= 1'b0;
         opt_ff       <= '0;
      end else if (selFall) begin
         addrLatch_ff <= pinIn.segmentAddr;
         dirLatch_ff  <= pinIn.playDir;
         opt_ff       <= isOpt ? vsc_pkg::vsc_opt_s'(pinIn.segmentAddr[`VSC_OPT_RANGE]) : '0;
      end
   end

   // Sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= vsc_pkg::VSC_IDLE;
      end else begin
         case (state_ff)
            vsc_pkg::VSC_IDLE: begin
               if (pinIn.lowPowerRequest) begin
                  state_ff <= vsc_pkg::VSC_SLEEP;
               end else if (start) begin
                  state_ff <= pinIn.playDir ? vsc_pkg::VSC_PLAY : vsc_pkg::VSC_REC;
               end
            end
            vsc_pkg::VSC_REC: begin
               if (selRise || lastTick) begin
                  state_ff <= vsc_pkg::VSC_IDLE;
               end
            end
            vsc_pkg::VSC_PLAY: begin
               if (selRise) begin
                  state_ff <= vsc_pkg::VSC_IDLE;
               end else if (lastTick || (segTick && endHit && !opt_ff.loop)) begin
                  state_ff <= vsc_pkg::VSC_IDLE;
               end
            end
            vsc_pkg::VSC_SLEEP: begin
               if (!pinIn.lowPowerRequest) begin
                  state_ff <= vsc_pkg::VSC_IDLE;
               end
            end
            default: state_ff <= vsc_pkg::VSC_IDLE;
         endcase
      end
   end

   // Segment pointer: load, auto-increment, loop, reset in low power
   always_ff @(posedge clk) begin
      if (rst) begin
         curSeg_ff   <= `VSC_SEG_FIRST;
         startSeg_ff <= `VSC_SEG_FIRST;
      end else if (state_ff == vsc_pkg::VSC_SLEEP) begin
         curSeg_ff <= `VSC_SEG_FIRST;
      end else if (start) begin
         curSeg_ff   <= startVal;
         startSeg_ff <= startVal;
      end else if (active && segTick && !lastTick && !selRise) begin
         if (state_ff == vsc_pkg::VSC_PLAY && endHit) begin
            curSeg_ff <= opt_ff.loop ? startSeg_ff : curSeg_ff;
         end else begin
            curSeg_ff <= curSeg_ff + `VSC_SEG_STEP;
         end
      end
   end

   // Overflow stays until low power resets the address
   always_ff @(posedge clk) begin
      if (rst) begin
         ovf_ff <= 1'b0;
      end else if (active && lastTick && !selRise) begin
         ovf_ff <= 1'b1;
      end else if (state_ff == vsc_pkg::VSC_SLEEP) begin
         ovf_ff <= 1'b0;
      end
   end

   // End flag: a new event wins over the clear at a fresh start
   always_ff @(posedge clk) begin
      if (rst) begin
         eomLow_ff <= 1'b0;
      end else if ((active && lastTick && !selRise) ||
                   (state_ff == vsc_pkg::VSC_PLAY && segTick && endHit && !opt_ff.ovfOnly)) begin
         eomLow_ff <= 1'b1;
      end else if (start || state_ff == vsc_pkg::VSC_SLEEP) begin
         eomLow_ff <= 1'b0;
      end
   end

   // End markers: erase first so a marker written now survives
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `VSC_SEG_COUNT; i++) begin
            mark_ff[i] <= 1'b0;
         end
      end else begin
         if (eraseReq) begin
            for (int i = 0; i < `VSC_SEG_COUNT; i++) begin
               mark_ff[i] <= 1'b0;
            end
         end
         if (state_ff == vsc_pkg::VSC_REC && selRise) begin
            mark_ff[curSeg_ff] <= 1'b1;
         end else if (state_ff == vsc_pkg::VSC_REC && segTick) begin
            mark_ff[curSeg_ff] <= 1'b0;
         end
      end
   end

   vsc_seg_timer #(
      .W       (32)
   ) u_timer (
      .clk     (clk),
      .rst     (rst),
      .run     (active),
      .restart (start),
      .period  (cfgTicks_ff),
      .tick    (segTick)
   );

   // Pin outputs decoded from sequencer state, end flag, latched direction, overflow and segment pointer
   always_comb begin
      pinOut              = '0;
      pinOut.msgEndFlagN  = !eomLow_ff;
      pinOut.speakerHold  = (state_ff == vsc_pkg::VSC_REC) || (state_ff == vsc_pkg::VSC_SLEEP);
      pinOut.auxRoute     = (state_ff == vsc_pkg::VSC_IDLE) && (dirLatch_ff || ovf_ff);
      pinOut.recordActive = (state_ff == vsc_pkg::VSC_REC);
      pinOut.playActive   = (state_ff == vsc_pkg::VSC_PLAY);
      pinOut.lowPowerMode = (state_ff == vsc_pkg::VSC_SLEEP);
      pinOut.curSegment   = curSeg_ff;
   end

   // Write channel: address and data held independently
   assign s_axi_awready = !awHeld_ff;
   assign s_axi_wready  = !wHeld_ff;
   assign doWrite       = awHeld_ff && wHeld_ff && !bvalid_ff;
   assign wSel          = regSel(awAddr_ff);
   assign eraseReq      = doWrite && (wSel == `VSC_SEL_ERASE)
                          && wStrb_ff[0] && wData_ff[`VSC_ERASE_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         awAddr_ff <= '0;
         wData_ff  <= `VSC_ZERO32;
         wStrb_ff  <= '0;
      end else begin
         if (s_axi_awvalid && !awHeld_ff) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_ff <= 1'b0;
         end
         if (s_axi_wvalid && !wHeld_ff) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_ff <= 1'b0;
         end
      end
   end

   // Segment period register, byte-lane writes
   always_ff @(posedge clk) begin
      if (rst) begin
         cfgTicks_ff <= 32'(SEG_TICKS);
      end else if (doWrite && wSel == `VSC_SEL_CFG) begin
         for (int b = 0; b < 4; b++) begin
            if (wStrb_ff[b]) begin
               cfgTicks_ff[b*8 +: 8] <= wData_ff[b*8 +: 8];
            end
         end
      end
   end

   // Write response; unmapped words answer SLVERR
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `VSC_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wSel == `VSC_SEL_NONE) ? `VSC_RESP_SLVERR : `VSC_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // Read channel; status word shows live sequencer state
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `VSC_ZERO32;
         rresp_ff  <= `VSC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= `VSC_RESP_OKAY;
         case (regSel(s_axi_araddr))
            `VSC_SEL_CFG:    rdata_ff <= cfgTicks_ff;
            `VSC_SEL_STATUS: rdata_ff <= {10'h000, opt_ff, curSeg_ff, 3'h0,
                                          ovf_ff, eomLow_ff, dirLatch_ff, state_ff};
            `VSC_SEL_ERASE:  rdata_ff <= `VSC_ZERO32;
            default: begin
               rdata_ff <= `VSC_ZERO32;
               rresp_ff <= `VSC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seqStart;
      start;
   endsequence

   sequence seqPlayDeselect;
      (state_ff == vsc_pkg::VSC_PLAY) && selRise;
   endsequence

   chk_seg_range: assert property (curSeg_ff <= `VSC_SEG_LAST)
      else $error("segment pointer beyond last segment");

   chk_lowpower_enter: assert property (
      (state_ff == vsc_pkg::VSC_IDLE) && pinIn.lowPowerRequest |=> pinOut.lowPowerMode && pinOut.speakerHold)
      else $error("idle low-power request did not sleep");

   chk_addr_reset: assert property (
      (state_ff == vsc_pkg::VSC_SLEEP) |=> (curSeg_ff == `VSC_SEG_FIRST) && !ovf_ff)
      else $error("low power did not reset address");

   chk_select_stop: assert property (active && selRise |=> state_ff == vsc_pkg::VSC_IDLE)
      else $error("select high did not stop cycle");

   chk_latch_addr: assert property (
      selFall |=> addrLatch_ff == $past(pinIn.segmentAddr) && dirLatch_ff == $past(pinIn.playDir))
      else $error("address or direction not latched");

   chk_aux_route: assert property (seqPlayDeselect |=> pinOut.auxRoute && !pinOut.speakerHold)
      else $error("aux input not routed after deselect");

   chk_rec_hold: assert property (
      $rose(state_ff == vsc_pkg::VSC_REC) |-> pinOut.speakerHold && !pinOut.auxRoute)
      else $error("speaker not held while recording");

   chk_dir_select: assert property (
      seqStart |=> (state_ff == ($past(pinIn.playDir) ? vsc_pkg::VSC_PLAY : vsc_pkg::VSC_REC)))
      else $error("direction pin chose wrong cycle");

   chk_opt_latch: assert property (selFall && isOpt |=> opt_ff == $past(pinIn.segmentAddr[`VSC_OPT_RANGE]))
      else $error("option bits not latched");

   chk_rec_incr: assert property (
      (state_ff == vsc_pkg::VSC_REC) && segTick && !lastTick && !selRise |=> curSeg_ff == $past(curSeg_ff) + 8'h01)
      else $error("record did not auto-increment");

   chk_eom_ovf: assert property (active && lastTick && !selRise |=> !pinOut.msgEndFlagN [*2])
      else $error("end flag not low on overflow");

endmodule

// ===== test/vsc_host_model.sv
`timescale 1ns/1ps
// Host side of the control pins: a controller that only ever moves pins just after a clock edge
module vsc_host_model (
   input  wire logic                  clk,     // System clock
   input  wire vsc_pkg::vsc_ctl_out_s pinOut,  // Device status pins
   output vsc_pkg::vsc_ctl_in_s       pinIn    // Control pins
);
   // Pins idle deselected, record direction, full power
   initial begin
      pinIn = '{selectN: 1'b1, playDir: 1'b0, segmentAddr: 8'h00, lowPowerRequest: 1'b0};
   end

   // Address and direction settle one cycle before select falls, so the latch sees stable levels
   task automatic begin_cycle(input logic dir, input logic [7:0] addr);
      @(posedge clk);
      pinIn.playDir     <= dir;
      pinIn.segmentAddr <= addr;
      @(posedge clk);
      pinIn.selectN     <= 1'b0;
   endtask

   // Deselect ends the cycle
   task automatic end_cycle();
      @(posedge clk);
      pinIn.selectN <= 1'b1;
   endtask

   // Low power is requested once no record or playback is running, or after 2000 cycles of waiting
   task automatic set_low_power(input logic on);
      int n = 0;
      while (on && (pinOut.recordActive || pinOut.playActive) && n < 2000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      pinIn.lowPowerRequest <= on;
   endtask
endmodule

// ===== test/voice_store_control_port_tb.sv
`timescale 1ns/1ps
`include "vsc_map.svh"
module voice_store_control_port_tb;
   localparam int unsigned Ticks = 4;
   localparam int          Cfg   = 8;
   logic                  clk, rst;
   logic [11:0]           s_axi_awaddr, s_axi_araddr;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0]           s_axi_wdata, s_axi_rdata;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   vsc_pkg::vsc_ctl_in_s  pinIn;
   vsc_pkg::vsc_ctl_out_s pinOut;
   int                    mismatches, totalChecks;
   int                    markQ[$];   // Model: segments carrying an end marker
   logic [31:0]           rng;

   vsc_control_port #(.SEG_TICKS(Ticks)) DUT (.clk(clk), .rst(rst), .pinIn(pinIn), .pinOut(pinOut),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   vsc_host_model host (.clk(clk), .pinOut(pinOut), .pinIn(pinIn));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Write: address and data offered together, each dropped once taken; bready held until bvalid
   task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
      bit done = 1'b0;
      @(posedge clk);
      s_axi_awaddr  <= addr;
      s_axi_wdata   <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      resp = 2'h1;
      while (!done) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   // Read: arvalid held until taken, rready held until rvalid
   task automatic axi_read(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
      bit done = 1'b0;
      @(posedge clk);
      s_axi_araddr  <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      data = 32'hDEAD_BEEF;
      resp = 2'h1;
      while (!done) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            data = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   // Hang guard, sized well above the whole sequence
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      final_report();
   end

   initial begin
      int          n, i, expSeg;
      logic [31:0] rd;
      logic [1:0]  resp;
      logic [7:0]  a;
      mismatches = 0;
      totalChecks = 0;
      rng = 32'h0000_004F;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check_flag(pinOut.msgEndFlagN, 1'b1);
      check_flag(pinOut.speakerHold, 1'b0);
      check_word(32'(pinOut.curSegment), 32'h0000_0000);
      // Register map: reset value, write and read back, unmapped word, marker erase
      axi_read(`VSC_REG_CFG, rd, resp);
      check_word(rd, Ticks);
      axi_write(`VSC_REG_CFG, Cfg, resp);
      check_word(32'(resp), `VSC_RESP_OKAY);
      axi_read(`VSC_REG_CFG, rd, resp);
      check_word(rd, Cfg);
      axi_read(`VSC_REG_STATUS, rd, resp);
      check_word(rd, 32'h0000_0000);
      axi_read(12'h00C, rd, resp);
      check_word(rd, 32'h0000_0000);
      check_word(32'(resp), `VSC_RESP_SLVERR);
      axi_write(12'h00C, 32'h0000_0001, resp);
      check_word(32'(resp), `VSC_RESP_SLVERR);
      axi_write(`VSC_REG_ERASE, 32'h0000_0001, resp);
      check_word(32'(resp), `VSC_RESP_OKAY);
      // Record from segment 5 across two segment boundaries
      host.begin_cycle(1'b0, 8'h05);
      for (n = 0; n < 6 && pinOut.recordActive !== 1'b1; n++) @(posedge clk);
      #1;
      check_flag(pinOut.recordActive, 1'b1);
      check_flag(pinOut.speakerHold, 1'b1);
      check_word(32'(pinOut.curSegment), 32'h0000_0005);
      for (n = 0; n < 3 * Cfg && pinOut.curSegment !== 8'h07; n++) @(posedge clk);
      #1;
      check_word(32'(pinOut.curSegment), 32'h0000_0007);
      host.end_cycle();
      markQ.push_back(7);
      for (n = 0; n < 4 && pinOut.recordActive !== 1'b0; n++) @(posedge clk);
      #1;
      check_flag(pinOut.recordActive, 1'b0);
      // Play from 5: runs until the marked segment, then flags the end
      host.begin_cycle(1'b1, 8'h05);
      for (n = 0; n < 6 && pinOut.playActive !== 1'b1; n++) @(posedge clk);
      #1;
      check_flag(pinOut.playActive, 1'b1);
      check_flag(pinOut.speakerHold, 1'b0);
      expSeg = 255;
      foreach (markQ[k]) if (markQ[k] >= 5 && markQ[k] < expSeg) expSeg = markQ[k];
      for (n = 0; n < 6 * Cfg && pinOut.msgEndFlagN !== 1'b0; n++) @(posedge clk);
      #1;
      check_flag(pinOut.msgEndFlagN, 1'b0);
      check_flag(pinOut.curSegment == expSeg || pinOut.curSegment == expSeg + 1, 1'b1);
      host.end_cycle();
      repeat (3) @(posedge clk);
      #1;
      check_flag(pinOut.auxRoute, 1'b1);
      // Random start segments, deselected early in playback
      for (i = 0; i < 4; i++) begin
         rng = xorshift(rng);
         a = 8'(rng % 160);
         host.begin_cycle(1'b1, a);
         for (n = 0; n < 6 && pinOut.playActive !== 1'b1; n++) @(posedge clk);
         #1;
         check_word(32'(pinOut.curSegment), 32'(a));
         check_flag(pinOut.auxRoute, 1'b0);
         host.end_cycle();
         repeat (3) @(posedge clk);
         #1;
         check_flag(pinOut.auxRoute, 1'b1);
      end
      // Consecutive option: playback resumes at the kept pointer, not at the address
      host.begin_cycle(1'b1, 8'hD0);
      for (n = 0; n < 6 && pinOut.playActive !== 1'b1; n++) @(posedge clk);
      #1;
      check_word(32'(pinOut.curSegment), 32'(a));
      host.end_cycle();
      repeat (3) @(posedge clk);
      // Option space without the consecutive bit: top two address bits high start at segment 0
      host.begin_cycle(1'b0, 8'hC0);
      for (n = 0; n < 6 && pinOut.recordActive !== 1'b1; n++) @(posedge clk);
      #1;
      check_word(32'(pinOut.curSegment), 32'h0000_0000);
      host.end_cycle();
      markQ.push_back(0);
      // Overflow from 157, then low power clears pointer and flag
      host.begin_cycle(1'b0, 8'd157);
      for (n = 0; n < 6 * Cfg && pinOut.msgEndFlagN !== 1'b0; n++) @(posedge clk);
      #1;
      check_flag(pinOut.msgEndFlagN, 1'b0);
      check_flag(pinOut.recordActive, 1'b0);
      host.end_cycle();
      host.set_low_power(1'b1);
      for (n = 0; n < 4 && pinOut.lowPowerMode !== 1'b1; n++) @(posedge clk);
      #1;
      check_flag(pinOut.lowPowerMode, 1'b1);
      check_flag(pinOut.speakerHold, 1'b1);
      host.begin_cycle(1'b0, 8'h05);
      repeat (4) @(posedge clk);
      #1;
      check_flag(pinOut.recordActive, 1'b0);
      host.end_cycle();
      host.set_low_power(1'b0);
      for (n = 0; n < 4 && pinOut.lowPowerMode !== 1'b0; n++) @(posedge clk);
      #1;
      check_word(32'(pinOut.curSegment), 32'h0000_0000);
      check_flag(pinOut.msgEndFlagN, 1'b1);
      final_report();
   end
endmodule
